/* design/pex_i2c_expander.sv */
// I2C slave framing for a 16-bit quasi-bidirectional port expander.
`timescale 1ns/1ps
module pex_i2c_expander (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        strap_sel_hi,
	input  wire logic        strap_sel_mid,
	input  wire logic        strap_sel_lo,
	input  wire logic [15:0] port_pins_in,
	input  wire logic        port_load_ready,
	output logic [15:0]      port_out,
	output logic             port_update
);

	// ==========================================================
	// Input synchronisers
	localparam int SYNC_W = 21;

	wire  [SYNC_W-1:0] sync_raw;
	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_s;
	logic              scl_d;
	logic              sda_d;

	assign sync_raw = {port_pins_in, strap_sel_hi, strap_sel_mid, strap_sel_lo, sda_in, scl_in};

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync_meta <= {SYNC_W{1'b1}};
			sync_s    <= {SYNC_W{1'b1}};
			scl_d     <= 1'b1;
			sda_d     <= 1'b1;
		end else begin
			sync_meta <= sync_raw;
			sync_s    <= sync_meta;
			scl_d     <= sync_s[0];
			sda_d     <= sync_s[1];
		end
	end

	wire        scl_s     = sync_s[0];
	wire        sda_s     = sync_s[1];
	wire [2:0]  strap_s   = sync_s[4:2];
	wire [15:0] pins_s    = sync_s[20:5];
	wire        scl_rise  = scl_s & ~scl_d;
	wire        scl_fall  = ~scl_s & scl_d;
	// Start and stop are SDA edges while SCL stays high
	wire        bus_start = scl_s & scl_d & sda_d & ~sda_s;
	wire        bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

	// ==========================================================
	// Bus state
	pex_pkg::pex_state_t state;
	logic [3:0]          bit_cnt;
	logic [7:0]          rx_shift;
	logic [7:0]          tx_shift;
	logic [7:0]          low_byte;
	logic [7:0]          high_hold;
	logic                second_byte;
	logic                ack_ok;
	logic                read_mode;

	wire [6:0] own_addr = {pex_pkg::PEX_ADDR_FIXED, strap_s};
	// Upper seven bits must match; general call cannot, its top nibble is zero
	wire       addr_hit = (rx_shift[7:1] == own_addr);
	wire       byte_done = (bit_cnt == pex_pkg::PEX_BYTE_BITS);

	// ==========================================================
	// Pair buffer between the receiver and the port latch
	pex_pkg::pex_pair_t push_pair;
	pex_pkg::pex_pair_t pop_pair;
	logic               push_valid;
	logic               buf_in_ready;
	logic               buf_out_valid;
	wire                buf_pop = buf_out_valid & port_load_ready;

	pex_pair_buffer #(
		.WIDTH($bits(pex_pkg::pex_pair_t)),
		.DEPTH(pex_pkg::PEX_BUF_DEPTH)
	) u_pair_buffer (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_valid  (push_valid),
		.in_ready  (buf_in_ready),
		.in_data   (push_pair),
		.out_valid (buf_out_valid),
		.out_ready (port_load_ready),
		.out_data  (pop_pair)
	);

	// ==========================================================
	// Bus state machine
	// Reset is the power-on release: every state register returns to default.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state       <= pex_pkg::PEX_IDLE;
			bit_cnt     <= 4'h0;
			rx_shift    <= 8'h00;
			tx_shift    <= 8'h00;
			low_byte    <= 8'h00;
			high_hold   <= 8'h00;
			second_byte <= 1'b0;
			ack_ok      <= 1'b0;
			read_mode   <= 1'b0;
			sda_oe      <= 1'b0;
			sda_out     <= 1'b0;
			push_valid  <= 1'b0;
			push_pair   <= '0;
		end else begin
			push_valid <= 1'b0;
			if (bus_start) begin
				state       <= pex_pkg::PEX_ADDR;
				bit_cnt     <= 4'h0;
				second_byte <= 1'b0;
				sda_oe      <= 1'b0;
			end else if (bus_stop) begin
				state  <= pex_pkg::PEX_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state)
				pex_pkg::PEX_IDLE: begin
					sda_oe <= 1'b0;
				end
				pex_pkg::PEX_ADDR: begin
					if (scl_rise) begin
						rx_shift <= {rx_shift[6:0], sda_s};
						bit_cnt  <= bit_cnt + 4'h1;
					end else if (scl_fall && byte_done) begin
						if (addr_hit) begin
							read_mode <= rx_shift[pex_pkg::PEX_ADDR_RW_BIT];
							sda_oe    <= 1'b1;
							state     <= pex_pkg::PEX_ADDR_ACK;
						end else begin
							state <= pex_pkg::PEX_IDLE;
						end
					end
				end
				pex_pkg::PEX_ADDR_ACK: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (read_mode) begin
							// Whole word is sampled at once so both halves agree
							high_hold <= pins_s[15:8];
							tx_shift  <= {pins_s[6:0], 1'b0};
							sda_oe    <= ~pins_s[7];
							bit_cnt   <= 4'h1;
							state     <= pex_pkg::PEX_TX;
						end else begin
							sda_oe <= 1'b0;
							state  <= pex_pkg::PEX_RX;
						end
					end
				end
				pex_pkg::PEX_RX: begin
					if (scl_rise) begin
						rx_shift <= {rx_shift[6:0], sda_s};
						bit_cnt  <= bit_cnt + 4'h1;
					end else if (scl_fall && byte_done) begin
						if (!second_byte) begin
							low_byte <= rx_shift;
							ack_ok   <= 1'b1;
							sda_oe   <= 1'b1;
						end else begin
							// A full buffer refuses the pair by not acknowledging
							ack_ok <= buf_in_ready;
							sda_oe <= buf_in_ready;
						end
						state <= pex_pkg::PEX_RX_ACK;
					end
				end
				pex_pkg::PEX_RX_ACK: begin
					if (scl_fall) begin
						sda_oe  <= 1'b0;
						bit_cnt <= 4'h0;
						if (!ack_ok) begin
							state <= pex_pkg::PEX_IDLE;
						end else begin
							if (second_byte) begin
								push_pair.high_port_half <= rx_shift;
								push_pair.low_port_half  <= low_byte;
								push_valid               <= 1'b1;
							end
							second_byte <= ~second_byte;
							state       <= pex_pkg::PEX_RX;
						end
					end
				end
				pex_pkg::PEX_TX: begin
					if (scl_fall) begin
						if (byte_done) begin
							sda_oe <= 1'b0;
							state  <= pex_pkg::PEX_TX_ACK;
						end else begin
							sda_oe   <= ~tx_shift[7];
							tx_shift <= {tx_shift[6:0], 1'b0};
							bit_cnt  <= bit_cnt + 4'h1;
						end
					end
				end
				pex_pkg::PEX_TX_ACK: begin
					if (scl_rise && sda_s) begin
						// Master NACK ends the read; wait for stop or restart
						state <= pex_pkg::PEX_IDLE;
					end else if (scl_fall) begin
						bit_cnt <= 4'h1;
						state   <= pex_pkg::PEX_TX;
						if (!second_byte) begin
							tx_shift    <= {high_hold[6:0], 1'b0};
							sda_oe      <= ~high_hold[7];
							second_byte <= 1'b1;
						end else begin
							high_hold   <= pins_s[15:8];
							tx_shift    <= {pins_s[6:0], 1'b0};
							sda_oe      <= ~pins_s[7];
							second_byte <= 1'b0;
						end
					end
				end
				default: begin
					state  <= pex_pkg::PEX_IDLE;
					sda_oe <= 1'b0;
				end
				endcase
			end
		end
	end

	// ==========================================================
	// Port latch: all sixteen outputs change together
	// Ones at power-up so every quasi-bidirectional pin starts usable as input.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			port_out    <= pex_pkg::PEX_PORT_RESET;
			port_update <= 1'b0;
		end else begin
			port_update <= buf_pop;
			if (buf_pop)
				port_out <= pop_pair;
		end
	end

endmodule

/* design/pex_pair_buffer.sv */
// Small valid/ready FIFO holding received port pairs.
`timescale 1ns/1ps
module pex_pair_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	wire              do_push;
	wire              do_pop;

	assign in_ready  = (count != (PW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign do_push   = in_valid & in_ready;
	assign do_pop    = out_valid & out_ready;

	// ==========================================================
	// Pointers wrap explicitly so DEPTH need not be a power of two
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push)
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			if (do_push && !do_pop)
				count <= count + 1'b1;
			else if (do_pop && !do_push)
				count <= count - 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (do_push)
			mem[wr_ptr] <= in_data;
	end

endmodule

/* design/pex_pkg.sv */
// Constants, carrier types and state codes for the I2C 16-bit port expander slave.
// How it works
// - The address byte arrives MSB first as fixed 0,1,0,0, then the straps high to low, then R/W.
// - The 8-bit address is even for writes and odd for reads, 0x40/0x41 up to 0x4E/0x4F.
// - The first byte of each pair maps to the low port half, bit 7 to its top pin.
// - The second byte of each pair maps to the high port half, bit 7 to its top pin.
// - Power-on reset holds the device and returns the bus machine and all state to defaults.
// - A write updates all sixteen outputs only after both bytes of a pair are acknowledged.
// - A read returns the present pin levels, low half first; inputs must be written high first.
// - The general call address is never acknowledged; only the strapped address is.
package pex_pkg;

	// ==========================================================
	// Address framing
	localparam logic [3:0] PEX_ADDR_FIXED    = 4'h4;
	localparam int         PEX_ADDR_FIX_MSB  = 7;
	localparam int         PEX_ADDR_FIX_LSB  = 4;
	localparam int         PEX_ADDR_STRAP_MSB = 3;
	localparam int         PEX_ADDR_STRAP_LSB = 1;
	localparam int         PEX_ADDR_RW_BIT   = 0;

	// ==========================================================
	// Byte and port constants
	localparam logic [3:0]  PEX_BYTE_BITS  = 4'h8;
	localparam logic [15:0] PEX_PORT_RESET = 16'hFFFF;
	localparam int          PEX_BUF_DEPTH  = 2;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic [7:0] high_port_half;
		logic [7:0] low_port_half;
	} pex_pair_t;

	typedef enum logic [6:0] {
		PEX_IDLE     = 7'b0000001,
		PEX_ADDR     = 7'b0000010,
		PEX_ADDR_ACK = 7'b0000100,
		PEX_RX       = 7'b0001000,
		PEX_RX_ACK   = 7'b0010000,
		PEX_TX       = 7'b0100000,
		PEX_TX_ACK   = 7'b1000000
	} pex_state_t;

endpackage

/* test/pex_expander_assertions.sv */
// Concurrent checks on the expander's bus and port outputs.
`timescale 1ns/1ps
module pex_expander_assertions (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        scl_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        port_load_ready,
	input wire logic [15:0] port_out,
	input wire logic        port_update
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_rst_dflt; $fell(rst) |-> (port_out == pex_pkg::PEX_PORT_RESET && !sda_oe) [*8]; endproperty
	a_rst_dflt: assert property (p_rst_dflt) else $error("no default after reset");
	// The latch and its update pulse load on the same edge, so both show together
	property p_upd_after; !$stable(port_out) |-> port_update; endproperty
	a_upd_after: assert property (p_upd_after) else $error("missing update pulse");
	property p_load_gate; !$stable(port_out) |-> $past(port_load_ready); endproperty
	a_load_gate: assert property (p_load_gate) else $error("load without ready");
	property p_upd_cause; port_update |-> $past(port_load_ready); endproperty
	a_upd_cause: assert property (p_upd_cause) else $error("stray update");
	property p_oe_rise; $rose(sda_oe) |-> !scl_in; endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("drive began in SCL high");
	property p_oe_steady; scl_in [*4] |-> $stable(sda_oe); endproperty
	a_oe_steady: assert property (p_oe_steady) else $error("SDA moved in SCL high");
	property p_oe_bound; $rose(sda_oe) |-> ##[1:200] !sda_oe; endproperty
	a_oe_bound: assert property (p_oe_bound) else $error("SDA held too long");
	property p_sda_low; sda_out == 1'b0; endproperty
	a_sda_low: assert property (p_sda_low) else $error("SDA driven high");
	cover property ($rose(sda_oe));
	cover property (port_update);
	cover property (!port_load_ready && $rose(sda_oe));
endmodule

/* test/pex_i2c_master.sv */
// Behavioural I2C master that drives the expander's bus pins.
`timescale 1ns/1ps
module pex_i2c_master (
	input  wire logic core_clk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_m
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// SDA moves only while SCL is low, except in START and STOP
	task automatic start();
		sda_m <= 1'b1;
		hold(2);
		scl <= 1'b1;
		hold(6);
		sda_m <= 1'b0;
		hold(6);
		scl <= 1'b0;
		hold(2);
	endtask
	task automatic stop();
		sda_m <= 1'b0;
		hold(5);
		scl <= 1'b1;
		hold(6);
		sda_m <= 1'b1;
		hold(8);
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_m <= b;
		hold(5);
		scl <= 1'b1;
		hold(6);
		r = sda_wire;
		scl <= 1'b0;
		hold(2);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
		output logic ak);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ai, ak);
	endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the expander with an I2C master model.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("ERROR %0t: got %h exp %h", $time, (a), (b)); end end
module tb_top;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        port_load_ready = 1'b1;
	logic [2:0]  strap = 3'h0;
	logic [15:0] pins = 16'h0000;
	logic [15:0] exp_out;
	logic [15:0] v0;
	logic [15:0] exp_head;
	logic [15:0] exp_q[$];
	logic [15:0] port_out;
	logic [7:0]  q;
	logic        scl, sda_m, sda_out, sda_oe, port_update, ak;
	int          errors = 0;
	int          check_count = 0;
	// Open-drain wire: released SDA is pulled high
	wire         sda_wire = sda_m & ~sda_oe;
	always #12.5 core_clk = ~core_clk;
	pex_i2c_master M (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl), .sda_m(sda_m));
	pex_i2c_expander DUT (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe(sda_oe), .strap_sel_hi(strap[2]), .strap_sel_mid(strap[1]),
		.strap_sel_lo(strap[0]), .port_pins_in(pins), .port_load_ready(port_load_ready),
		.port_out(port_out), .port_update(port_update));
	task automatic final_report();
		$display("Checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Model: a stalled latch side refuses the pair once the buffer holds two
	task automatic wpair(input logic [7:0] a, input int pairs, input logic ak0);
		logic [15:0] v;
		logic        exp_nak;
		M.start();
		M.xfer(a, 1'b1, q, ak);
		`CHK(ak, ak0)
		for (int i = 0; i < pairs && !ak; i++) begin
			v = 16'($urandom);
			M.xfer(v[7:0], 1'b1, q, ak);
			`CHK(ak, 1'b0)
			exp_nak = (exp_q.size() >= pex_pkg::PEX_BUF_DEPTH);
			M.xfer(v[15:8], 1'b1, q, ak);
			`CHK(ak, exp_nak)
			if (!exp_nak) begin
				exp_out = v;
				exp_q.push_back(v);
			end
		end
		M.stop();
	endtask
	// Every update pulse must carry the oldest accepted pair, in order
	always @(negedge core_clk) begin
		if (!rst && port_update) begin
			`CHK(exp_q.size() != 0, 1'b1)
			if (exp_q.size() != 0) begin
				exp_head = exp_q.pop_front();
				`CHK(port_out, exp_head)
			end
		end
	end
	task automatic rd(input logic [7:0] a, input int n);
		M.start();
		M.xfer(a, 1'b1, q, ak);
		`CHK(ak, 1'b0)
		for (int i = 0; i < n; i++) begin
			M.xfer(8'hFF, i == n - 1, q, ak);
			`CHK(q, i[0] ? pins[15:8] : pins[7:0])
		end
		M.stop();
	endtask
	initial begin
		void'($urandom(32'h68CD122A));
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		M.hold(4);
		exp_out = 16'hFFFF;
		`CHK(port_out, exp_out)
		for (int s = 0; s < 8; s++) begin
			strap <= s[2:0];
			pins <= 16'($urandom);
			M.hold(4);
			wpair(8'h40 + 8'(2 * s), 1 + s % 3, 1'b0);
			`CHK(port_out, exp_out)
			wpair(8'h40 + 8'(2 * ((s + 1) % 8)), 1, 1'b1);
			`CHK(port_out, exp_out)
			rd(8'h41 + 8'(2 * s), 4);
		end
		$display("Address sweep done");
		wpair(8'h00, 1, 1'b1);
		M.start();
		M.xfer(8'h4E, 1'b1, q, ak);
		M.xfer(8'h5A, 1'b1, q, ak);
		M.stop();
		`CHK(port_out, exp_out)
		$display("General call and lone byte done");
		v0 = exp_out;
		port_load_ready <= 1'b0;
		wpair(8'h4E, 3, 1'b0);
		`CHK(ak, 1'b1)
		`CHK(port_out, v0)
		port_load_ready <= 1'b1;
		M.hold(8);
		`CHK(port_out, exp_out)
		$display("Buffer stall done");
		rst <= 1'b1;
		M.hold(4);
		rst <= 1'b0;
		M.hold(4);
		exp_out = 16'hFFFF;
		`CHK(port_out, exp_out)
		wpair(8'h4E, 1, 1'b0);
		`CHK(port_out, exp_out)
		$display("Reset in mid-run done");
		`CHK(exp_q.size(), 0)
		final_report();
	end
	initial begin
		#1500000;
		errors++;
		final_report();
	end
endmodule
bind pex_i2c_expander pex_expander_assertions u_chk (.core_clk(core_clk), .rst(rst),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .port_load_ready(port_load_ready),
	.port_out(port_out), .port_update(port_update));
